// ---- rtl/prot_ctrl.sv ----
module prot_ctrl
   import prot_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // device command cycles
   output prot_ctrl_pkg::dev_cmd_t devCmd,
   input wire prot_ctrl_pkg::dev_rsp_t devRsp
);
   import prot_ctrl_pkg::*;

   typedef enum logic [1:0] {S_IDLE = 2'b01, S_RUN = 2'b10} state_t;

   state_t state_q;
   op_t op_q;
   mode_t mode_q;
   logic [2:0] step_q;
   logic [1:0] portion_q;
   logic [1:0] nextPortion_q;
   logic portionsDone_q;
   logic [ADDR_W-1:0] sect_q;
   logic [15:0] pwdWord_q [4];
   logic [15:0] readWord_q [4];
   logic done_q;
   logic err_q;
   dev_cmd_t cmd_q;
   logic [31:0] prdata_q;
   logic [63:0] pwdFlat;
   cycle_t nextCyc;
   cycle_t curCyc;
   logic apbWr;
   logic apbSetup;
   logic startReq;
   op_t reqOp;
   logic [1:0] reqPortion;
   logic legal;
   logic go;
   logic accept;
   logic finish;

   // ===========================================
   // sequence table
   function automatic cycle_t seqCycle(input op_t op, input logic [2:0] st,
         input logic [ADDR_W-1:0] sect, input logic [1:0] por,
         input logic [63:0] pw);
      cycle_t c;
      logic [ADDR_W-1:0] idx;
      c = '{write: 1'b1, addr: ADDR_ZERO, data: DAT_EXIT_2, last: 1'b0};
      idx = {{(ADDR_W-3){1'b0}}, st};
      unique case (op)
         OP_PWD_ENTRY, OP_PPB_ENTRY: begin
            c.last = (st == 3'd2);
            if (st == 3'd0) begin
               c.addr = ADDR_UNLOCK_A;
               c.data = DAT_UNLOCK_A;
            end else if (st == 3'd1) begin
               c.addr = ADDR_UNLOCK_B;
               c.data = DAT_UNLOCK_B;
            end else begin
               c.addr = ADDR_UNLOCK_A;
               c.data = (op == OP_PWD_ENTRY) ? DAT_PWD_SPACE : DAT_PPB_SPACE;
            end
         end
         OP_PWD_PROG: begin
            c.last = (st == 3'd1);
            c.data = (st == 3'd0) ? DAT_PROGRAM : pw[16*por +: 16];
            c.addr = (st == 3'd0) ? ADDR_ZERO :
                     {{(ADDR_W-2){1'b0}}, por};
         end
         OP_PWD_READ: begin
            c.write = 1'b0;
            c.addr = idx;
            c.last = (st == 3'd3);
         end
         OP_PWD_UNLOCK: begin
            c.last = (st == 3'd6);
            if (st == 3'd0) begin
               c.data = DAT_UNLOCK_1;
            end else if (st == 3'd1) begin
               c.data = DAT_UNLOCK_2;
            end else if (st == 3'd6) begin
               c.data = DAT_UNLOCK_GO;
            end else begin
               c.addr = idx - 25'd2;
               c.data = pw[16*(st-3'd2) +: 16];
            end
         end
         OP_EXIT: begin
            c.last = (st == 3'd1);
            c.data = (st == 3'd0) ? DAT_EXIT_1 : DAT_EXIT_2;
         end
         OP_RESET: begin
            c.last = 1'b1;
            c.data = DAT_RESET;
         end
         OP_PPB_PROG: begin
            c.last = (st == 3'd1);
            c.addr = (st == 3'd0) ? ADDR_ZERO : sect;
            c.data = (st == 3'd0) ? DAT_PROGRAM : DAT_LOCK_SET;
         end
         OP_PPB_ERASE: begin
            c.last = (st == 3'd1);
            c.data = (st == 3'd0) ? DAT_ERASE_1 : DAT_ERASE_2;
         end
         OP_PPB_READ: begin
            c.write = 1'b0;
            c.addr = sect;
            c.last = 1'b1;
         end
         OP_STATUS: begin
            c.last = (st == 3'd1);
            c.write = (st == 3'd0);
            c.addr = (st == 3'd0) ? ADDR_ZERO : sect;
            c.data = DAT_STATUS_Q;
         end
         default: c.last = 1'b1;
      endcase
      return c;
   endfunction : seqCycle

   // ===========================================
   // request check
   assign apbSetup = psel && !penable;
   assign apbWr = psel && penable && pwrite;
   assign startReq = apbWr && (paddr == OFF_CTRL) && pwdata[CTRL_START_BIT];
   assign reqOp = op_t'(pwdata[3:0]);
   assign reqPortion = pwdata[CTRL_PORTION_LSB +: 2];

   always_comb begin
      unique case (reqOp)
         OP_PWD_ENTRY, OP_PPB_ENTRY: legal = (mode_q == MODE_ARRAY);
         OP_PWD_PROG: legal = (mode_q == MODE_PWD) && !portionsDone_q &&
                              (reqPortion == nextPortion_q);
         OP_PWD_READ, OP_PWD_UNLOCK: legal = (mode_q == MODE_PWD);
         OP_EXIT, OP_RESET: legal = 1'b1;
         OP_PPB_PROG, OP_PPB_ERASE, OP_PPB_READ: legal = (mode_q == MODE_PPB);
         OP_STATUS: legal = (mode_q == MODE_PPB);
         default: legal = 1'b0;
      endcase
   end

   assign go = startReq && (state_q == S_IDLE);
   assign accept = go && legal;
   assign finish = (state_q == S_RUN) && devRsp.ready && curCyc.last;
   assign pwdFlat = {pwdWord_q[3], pwdWord_q[2], pwdWord_q[1], pwdWord_q[0]};
   assign curCyc = seqCycle(op_q, step_q, sect_q, portion_q, pwdFlat);
   assign nextCyc = seqCycle(reqOp, 3'd0, sect_q, reqPortion, pwdFlat);

   // ===========================================
   // sequencer
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_q <= S_IDLE;
         op_q <= OP_RESET;
         step_q <= 3'd0;
         portion_q <= 2'd0;
      end else if (accept) begin
         state_q <= S_RUN;
         op_q <= reqOp;
         step_q <= 3'd0;
         portion_q <= reqPortion;
      end else if (state_q == S_RUN && devRsp.ready) begin
         step_q <= step_q + 3'd1;
         if (curCyc.last) begin
            state_q <= S_IDLE;
         end
      end
   end

   // cycle held stable until the device takes it
   always_ff @(posedge clk) begin
      cycle_t n;
      n = seqCycle(op_q, step_q + 3'd1, sect_q, portion_q, pwdFlat);
      if (!nrst) begin
         cmd_q <= '0;
      end else if (accept) begin
         cmd_q <= '{valid: 1'b1, write: nextCyc.write, addr: nextCyc.addr,
                    wdata: nextCyc.data};
      end else if (state_q == S_RUN && devRsp.ready) begin
         cmd_q <= '{valid: !curCyc.last, write: n.write, addr: n.addr,
                    wdata: n.data};
      end
   end
   assign devCmd = cmd_q;

   // only the answer of each single read is kept, all 16 bits
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) begin
            readWord_q[i] <= 16'h0000;
         end
      end else if (state_q == S_RUN && devRsp.ready && !cmd_q.write) begin
         readWord_q[step_q[1:0]] <= devRsp.rdata;
      end
   end

   // ===========================================
   // overlay mode and portion order tracking
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mode_q <= MODE_ARRAY;
      end else if (finish) begin
         unique case (op_q)
            OP_PWD_ENTRY: mode_q <= MODE_PWD;
            OP_PPB_ENTRY: mode_q <= MODE_PPB;
            OP_EXIT, OP_RESET: mode_q <= MODE_ARRAY;
            default: mode_q <= mode_q;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         nextPortion_q <= 2'd0;
         portionsDone_q <= 1'b0;
      end else if (finish && op_q == OP_PWD_PROG) begin
         nextPortion_q <= nextPortion_q + 2'd1;
         portionsDone_q <= (nextPortion_q == 2'd3);
      end
   end

   // ===========================================
   // status flags: hardware set wins over software clear
   always_ff @(posedge clk) begin
      if (!nrst) begin
         done_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         if (finish) begin
            done_q <= 1'b1;
         end else if (apbWr && paddr == OFF_STAT && pwdata[STAT_DONE_BIT]) begin
            done_q <= 1'b0;
         end
         if (go && !legal) begin
            err_q <= 1'b1;
         end else if (apbWr && paddr == OFF_STAT && pwdata[STAT_ERR_BIT]) begin
            err_q <= 1'b0;
         end
      end
   end

   // ===========================================
   // apb registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sect_q <= ADDR_ZERO;
      end else if (apbWr && paddr == OFF_SECT && state_q == S_IDLE) begin
         sect_q <= pwdata[ADDR_W-1:0];
      end
   end

   for (genvar g = 0; g < 4; g++) begin : g_pwd
      always_ff @(posedge clk) begin
         if (!nrst) begin
            pwdWord_q[g] <= PWD_RESET;
         end else if (apbWr && state_q == S_IDLE &&
                      paddr == OFF_PWD + 8'(4*g)) begin
            pwdWord_q[g] <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata_q <= 32'h00000000;
      end else if (apbSetup) begin
         unique case (paddr)
            OFF_SECT: prdata_q <= {{(32-ADDR_W){1'b0}}, sect_q};
            OFF_STAT: prdata_q <= {26'h0, mode_q, 1'b0, err_q, done_q,
                                   state_q == S_RUN};
            OFF_PWD: prdata_q <= {16'h0, pwdWord_q[0]};
            OFF_PWD + 8'h04: prdata_q <= {16'h0, pwdWord_q[1]};
            OFF_PWD + 8'h08: prdata_q <= {16'h0, pwdWord_q[2]};
            OFF_PWD + 8'h0c: prdata_q <= {16'h0, pwdWord_q[3]};
            OFF_READ: prdata_q <= {16'h0, readWord_q[0]};
            OFF_READ + 8'h04: prdata_q <= {16'h0, readWord_q[1]};
            OFF_READ + 8'h08: prdata_q <= {16'h0, readWord_q[2]};
            OFF_READ + 8'h0c: prdata_q <= {16'h0, readWord_q[3]};
            default: prdata_q <= 32'h00000000;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = psel && penable;
   assign pslverr = psel && penable && !(paddr == OFF_CTRL ||
      paddr == OFF_SECT || paddr == OFF_STAT ||
      (paddr[7:4] == OFF_PWD[7:4] && paddr[1:0] == 2'b00) ||
      (paddr[7:4] == OFF_READ[7:4] && paddr[1:0] == 2'b00 && !pwrite));

   // ===========================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_accept(op_t o);
      accept && reqOp == o;
   endsequence

   a_pwd_entry_seq: assert property (s_accept(OP_PWD_ENTRY) |=>
      devCmd.addr == ADDR_UNLOCK_A && devCmd.wdata == DAT_UNLOCK_A)
      else $error("password entry does not start with unlock");
   a_ppb_entry_seq: assert property (state_q == S_RUN &&
      op_q == OP_PPB_ENTRY && step_q == 3'd2 |->
      devCmd.addr == ADDR_UNLOCK_A && devCmd.wdata == DAT_PPB_SPACE)
      else $error("lock space entry third cycle wrong");
   a_cmd_hold_stable: assert property (devCmd.valid && !devRsp.ready |=>
      devCmd.valid && $stable(devCmd))
      else $error("cycle changed before taken");
   a_portion_order: assert property (go && reqOp == OP_PWD_PROG &&
      reqPortion != nextPortion_q |=> err_q && state_q == S_IDLE)
      else $error("out of order portion not refused");
   a_unlock_final: assert property (state_q == S_RUN &&
      op_q == OP_PWD_UNLOCK && step_q == 3'd6 |->
      devCmd.wdata == DAT_UNLOCK_GO && devCmd.addr == ADDR_ZERO)
      else $error("unlock last cycle wrong");
   a_exit_mode: assert property (finish && op_q == OP_EXIT |=>
      mode_q == MODE_ARRAY && done_q)
      else $error("exit did not return to array");
   a_reset_single: assert property (s_accept(OP_RESET) |=>
      devCmd.wdata == DAT_RESET ##1 !devCmd.valid || !$past(devRsp.ready))
      else $error("reset cycle wrong");
   a_erase_second: assert property (state_q == S_RUN &&
      op_q == OP_PPB_ERASE && step_q == 3'd1 |->
      devCmd.wdata == DAT_ERASE_2 && devCmd.addr == ADDR_ZERO)
      else $error("erase second cycle wrong");
   a_status_read: assert property (state_q == S_RUN &&
      op_q == OP_STATUS && step_q == 3'd1 |->
      !devCmd.write && devCmd.addr == sect_q)
      else $error("status query second cycle not a sector read");
   a_lock_program: assert property (state_q == S_RUN &&
      op_q == OP_PPB_PROG && step_q == 3'd1 |->
      devCmd.write && devCmd.wdata == DAT_LOCK_SET && devCmd.addr == sect_q)
      else $error("lock program second cycle wrong");
   a_entry_refused: assert property (go && mode_q != MODE_ARRAY &&
      (reqOp == OP_PWD_ENTRY || reqOp == OP_PPB_ENTRY) |=> err_q)
      else $error("entry inside overlay space not refused");
endmodule : prot_ctrl

// ---- rtl/prot_ctrl_pkg.sv ----
package prot_ctrl_pkg;
   // ===========================================
   // device word cycles (16-bit word addressing)
   localparam int ADDR_W = 25;
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK_A = 25'h0000555;
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK_B = 25'h00002aa;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 25'h0000000;
   localparam logic [15:0] DAT_UNLOCK_A = 16'h00aa;
   localparam logic [15:0] DAT_UNLOCK_B = 16'h0055;
   localparam logic [15:0] DAT_PWD_SPACE = 16'h0060;
   localparam logic [15:0] DAT_PPB_SPACE = 16'h00c0;
   localparam logic [15:0] DAT_PROGRAM = 16'h00a0;
   localparam logic [15:0] DAT_UNLOCK_1 = 16'h0025;
   localparam logic [15:0] DAT_UNLOCK_2 = 16'h0003;
   localparam logic [15:0] DAT_UNLOCK_GO = 16'h0029;
   localparam logic [15:0] DAT_EXIT_1 = 16'h0090;
   localparam logic [15:0] DAT_EXIT_2 = 16'h0000;
   localparam logic [15:0] DAT_RESET = 16'h00f0;
   localparam logic [15:0] DAT_ERASE_1 = 16'h0080;
   localparam logic [15:0] DAT_ERASE_2 = 16'h0030;
   localparam logic [15:0] DAT_STATUS_Q = 16'h0060;
   localparam logic [15:0] DAT_LOCK_SET = 16'h0000;

   // ===========================================
   // APB register map (byte offsets)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SECT = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_PWD = 8'h10;
   localparam logic [7:0] OFF_READ = 8'h20;
   localparam int CTRL_START_BIT = 8;
   localparam int CTRL_PORTION_LSB = 16;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_ERR_BIT = 2;
   localparam int STAT_MODE_LSB = 4;
   localparam logic [15:0] PWD_RESET = 16'hffff;

   typedef enum logic [3:0] {
      OP_PWD_ENTRY = 4'h0, OP_PWD_PROG = 4'h1, OP_PWD_READ = 4'h2,
      OP_PWD_UNLOCK = 4'h3, OP_EXIT = 4'h4, OP_RESET = 4'h5,
      OP_PPB_ENTRY = 4'h6, OP_PPB_PROG = 4'h7, OP_PPB_ERASE = 4'h8,
      OP_PPB_READ = 4'h9, OP_STATUS = 4'ha
   } op_t;

   typedef enum logic [1:0] {
      MODE_ARRAY = 2'h0, MODE_PWD = 2'h1, MODE_PPB = 2'h2
   } mode_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [15:0] wdata;
   } dev_cmd_t;

   typedef struct packed {
      logic ready;
      logic [15:0] rdata;
   } dev_rsp_t;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [15:0] data;
      logic last;
   } cycle_t;
endpackage : prot_ctrl_pkg

// ---- test/dev_model.sv ----
// ===========================================
// behavioural flash protection command decoder
module dev_model
   import prot_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // stall control
   input wire logic slow,
   // command cycles
   input wire prot_ctrl_pkg::dev_cmd_t devCmd,
   output prot_ctrl_pkg::dev_rsp_t devRsp
);
   timeunit 1ns;
   timeprecision 1ps;
   mode_t mode_q;
   logic [1:0] step_q;
   logic [2:0] unl_q;
   logic prog_q, exit_q, erase_q, stat_q, rdy_q;
   logic [15:0] pwd_q [4];
   logic ppb_q [256];
   logic [15:0] junk_q;
   logic take;
   logic [7:0] lo;
   logic [10:0] a;
   logic [7:0] sec;

   assign take = devCmd.valid & rdy_q;
   assign lo = devCmd.wdata[7:0]; // upper byte ignored
   assign a = devCmd.addr[10:0]; // high bits ignored
   assign sec = devCmd.addr[24:17]; // offset inside sector ignored

   always_ff @(posedge clk) begin
      rdy_q <= ~slow | 1'($urandom & 1);
      // seeded at reset so the idle bus never carries unknowns
      junk_q <= nrst ? ~junk_q ^ 16'h3c5a : 16'h1234;
   end

   // ===========================================
   // read data: only the taken word is meaningful
   always_comb begin
      devRsp.ready = rdy_q;
      devRsp.rdata = junk_q; // undriven bus keeps moving
      if (take && !devCmd.write) begin
         if (mode_q == MODE_PWD) begin
            devRsp.rdata = pwd_q[devCmd.addr[1:0]];
         end else if (mode_q == MODE_PPB && stat_q) begin
            devRsp.rdata = {13'h1fff, ppb_q[sec], 1'b1, ppb_q[sec]};
         end else if (mode_q == MODE_PPB) begin
            devRsp.rdata = {15'h7fff, ppb_q[sec]};
         end
      end
   end

   // ===========================================
   // sequence tracking
   always_ff @(posedge clk) begin
      if (!nrst) begin
         mode_q <= MODE_ARRAY;
         step_q <= 2'h0;
         unl_q <= 3'h0;
         {prog_q, exit_q, erase_q, stat_q} <= 4'h0;
         for (int i = 0; i < 4; i++) pwd_q[i] <= 16'hffff;
         for (int i = 0; i < 256; i++) ppb_q[i] <= 1'b1;
      end else if (take) begin
         {prog_q, exit_q, erase_q, stat_q} <= 4'h0;
         if (!devCmd.write) begin
         end else if (unl_q != 3'h0) begin
            unl_q <= unl_q - 3'h1; // 03, password words and final 29
         end else if (prog_q && mode_q == MODE_PWD) begin
            // a password word may hold any low byte, even f0
            pwd_q[devCmd.addr[1:0]] <= devCmd.wdata;
         end else if (lo == 8'hf0) begin
            mode_q <= MODE_ARRAY;
            step_q <= 2'h0;
         end else if (exit_q && lo == 8'h00) begin
            mode_q <= MODE_ARRAY;
         end else if (prog_q && lo == 8'h00) begin
            ppb_q[sec] <= 1'b0;
         end else if (erase_q && lo == 8'h30 && a == 11'h000) begin
            for (int i = 0; i < 256; i++) ppb_q[i] <= 1'b1;
         end else if (mode_q == MODE_PWD && lo == 8'h25) begin
            unl_q <= 3'h6;
         end else if (mode_q != MODE_ARRAY) begin
            prog_q <= lo == 8'ha0;
            exit_q <= lo == 8'h90;
            erase_q <= lo == 8'h80 && mode_q == MODE_PPB;
            stat_q <= lo == 8'h60 && mode_q == MODE_PPB;
         end else begin
            // any mismatch drops the partial entry
            step_q <= 2'h0;
            case (step_q)
               2'h0: if (lo == 8'haa && a == 11'h555) step_q <= 2'h1;
               2'h1: if (lo == 8'h55 && a == 11'h2aa) step_q <= 2'h2;
               default: begin
                  if (a == 11'h555 && lo == 8'h60) mode_q <= MODE_PWD;
                  if (a == 11'h555 && lo == 8'hc0) mode_q <= MODE_PPB;
               end
            endcase
         end
      end
   end
endmodule : dev_model

// ---- test/tb.sv ----
module tb;
   import prot_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic w;
      logic [24:0] a, am;
      logic [15:0] d, dm;
   } exp_t;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, slow, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   dev_cmd_t devCmd;
   dev_rsp_t devRsp;
   exp_t expQ[$];
   exp_t cur;
   int miscompares, checked;
   logic [15:0] pw [4];
   logic [24:0] sect;

   prot_ctrl u_prot_ctrl (.clk(clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .devCmd(devCmd), .devRsp(devRsp));
   dev_model u_dev_model (.clk(clk), .nrst(nrst), .slow(slow),
      .devCmd(devCmd), .devRsp(devRsp));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ===========================================
   // helpers
   task automatic give_verdict();
      $display("checked %0d, miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] x);
      checked++;
      if (seen !== x) begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, x);
      end
   endtask : check

   task automatic apb(input logic w, input logic [7:0] ad,
         input logic [31:0] wd, output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      if (n >= 50) check(32'(pready), 32'h1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, ad, d, r, e);
   endtask : wr

   task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, ad, 32'h0, r, e);
      check(r, x);
   endtask : rdc

   task automatic expc(input logic w, input logic [24:0] a, am,
         input logic [15:0] d, dm);
      expQ.push_back('{w, a, am, d, dm});
   endtask : expc

   // command word: only the low byte counts
   task automatic cmd(input logic [24:0] a, am, input logic [7:0] d);
      expc(1'b1, a, am, {8'h00, d}, 16'h00ff);
   endtask : cmd

   task automatic op(input op_t o, input logic [1:0] por, input logic bad);
      logic [31:0] r = 32'h0;
      logic e;
      int n = 0;
      wr(OFF_CTRL, {14'h0, por, 7'h0, 1'b1, 4'h0, o});
      while (r[STAT_DONE_BIT] !== 1'b1 && r[STAT_ERR_BIT] !== 1'b1
            && n < 200) begin
         apb(1'b0, OFF_STAT, 32'h0, r, e);
         n++;
      end
      check(32'(r[STAT_DONE_BIT] | r[STAT_ERR_BIT]), 32'h1);
      check(32'(r[STAT_ERR_BIT]), 32'(bad));
      check(32'(expQ.size()), 32'h0);
      wr(OFF_STAT, 32'h6);
   endtask : op

   // ===========================================
   // device cycle monitor
   always @(posedge clk) begin
      if (nrst && devCmd.valid && devRsp.ready) begin
         if (expQ.size() == 0) begin
            miscompares++;
            $display("mismatch at %0t: unexpected device cycle", $time);
         end else begin
            cur = expQ.pop_front();
            check(32'(devCmd.write), 32'(cur.w));
            check(32'(devCmd.addr & cur.am), 32'(cur.a & cur.am));
            if (cur.w) check(32'(devCmd.wdata & cur.dm), 32'(cur.d & cur.dm));
         end
      end
   end

   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      $display("mismatch at %0t: watchdog expired", $time);
      give_verdict();
   end

   // ===========================================
   // main sequence
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, slow} = '0;
      miscompares = 0;
      checked = 0;
      void'($urandom(32'h4a75));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      rdc(OFF_STAT, 32'h0);
      for (int p = 0; p < 4; p++) rdc(8'(OFF_PWD + 4 * p), {16'h0, PWD_RESET});
      apb(1'b0, 8'hfc, 32'h0, rd, err);
      check(32'(err), 32'h1);
      slow <= 1'b1;
      cmd(ADDR_UNLOCK_A, 25'h7ff, 8'haa);
      cmd(ADDR_UNLOCK_B, 25'h7ff, 8'h55);
      cmd(ADDR_UNLOCK_A, 25'h7ff, 8'h60);
      op(OP_PWD_ENTRY, 2'h0, 1'b0);
      rdc(OFF_STAT, 32'h10);
      op(OP_PWD_PROG, 2'h1, 1'b1); // out of order refused
      for (int p = 0; p < 4; p++) begin
         pw[p] = 16'($urandom);
         wr(8'(OFF_PWD + 4 * p), {16'h0, pw[p]});
         cmd(ADDR_ZERO, 25'h0, 8'ha0);
         expc(1'b1, 25'(p), '1, pw[p], 16'hffff);
         op(OP_PWD_PROG, 2'(p), 1'b0);
      end
      op(OP_PWD_PROG, 2'h0, 1'b1); // all four done
      for (int p = 0; p < 4; p++) expc(1'b0, 25'(p), '1, 16'h0, 16'h0);
      op(OP_PWD_READ, 2'h0, 1'b0);
      for (int p = 0; p < 4; p++) rdc(8'(OFF_READ + 4 * p), {16'h0, pw[p]});
      cmd(ADDR_ZERO, 25'h7ff, 8'h25);
      cmd(ADDR_ZERO, 25'h7ff, 8'h03);
      for (int p = 0; p < 4; p++) expc(1'b1, 25'(p), '1, pw[p], 16'hffff);
      cmd(ADDR_ZERO, 25'h7ff, 8'h29);
      op(OP_PWD_UNLOCK, 2'h0, 1'b0);
      cmd(ADDR_ZERO, 25'h0, 8'h90);
      cmd(ADDR_ZERO, 25'h0, 8'h00);
      op(OP_EXIT, 2'h0, 1'b0);
      rdc(OFF_STAT, 32'h0);
      op(OP_PPB_PROG, 2'h0, 1'b1); // wrong mode
      cmd(ADDR_UNLOCK_A, 25'h7ff, 8'haa);
      cmd(ADDR_UNLOCK_B, 25'h7ff, 8'h55);
      cmd(ADDR_UNLOCK_A, 25'h7ff, 8'hc0);
      op(OP_PPB_ENTRY, 2'h0, 1'b0);
      rdc(OFF_STAT, 32'h20);
      op(OP_PWD_ENTRY, 2'h0, 1'b1); // entry outside array mode
      sect = 25'($urandom);
      wr(OFF_SECT, 32'(sect));
      cmd(ADDR_ZERO, 25'h0, 8'ha0);
      cmd(sect, 25'h1fe0000, 8'h00);
      op(OP_PPB_PROG, 2'h0, 1'b0);
      expc(1'b0, sect, 25'h1fe0000, 16'h0, 16'h0);
      op(OP_PPB_READ, 2'h0, 1'b0);
      rdc(OFF_READ, 32'h0000fffe);
      for (int k = 0; k < 2; k++) begin
         if (k == 1) begin
            cmd(ADDR_ZERO, 25'h0, 8'h80);
            cmd(ADDR_ZERO, 25'h7ff, 8'h30);
            op(OP_PPB_ERASE, 2'h0, 1'b0);
         end
         cmd(ADDR_ZERO, 25'h0, 8'h60);
         expc(1'b0, sect, 25'h1fe0000, 16'h0, 16'h0);
         op(OP_STATUS, 2'h0, 1'b0);
         rdc(8'(OFF_READ + 4), k ? 32'h0000ffff : 32'h0000fffa);
      end
      cmd(ADDR_ZERO, 25'h0, 8'hf0);
      op(OP_RESET, 2'h0, 1'b0);
      rdc(OFF_STAT, 32'h0);
      give_verdict();
   end
endmodule : tb
